// ===== design/fecr_chain_decode.sv
// Combinational decode of the filter chain register into lane enables
// and the output rate actually supported by the chosen output stage.
// Assumes the caller registers every result.
`timescale 1ns/1ps
module fecr_chain_decode (
  // Stored configuration
  input  fecr_pkg::fecr_filter_cfg_s cfg_i,
  // Decoded results
  output logic [3:0]                 lane_mask_o,
  output logic [2:0]                 eff_rate_o,
  output logic                       stage_rsvd_o
);

  // Channels enable in order; code zero means all four
  always_comb begin
    unique case (cfg_i.active_lane_count)
      2'h1: lane_mask_o = 4'h1;
      2'h2: lane_mask_o = 4'h3;
      2'h3: lane_mask_o = 4'h7;
      2'h0: lane_mask_o = 4'hF;
    endcase
  end

  // Unsupported rates fall to the closest supported one
  always_comb begin
    eff_rate_o = cfg_i.output_rate_select;
    if (cfg_i.output_stage_select == fecr_pkg::FECR_STAGE_SINC) begin
      eff_rate_o = fecr_pkg::FECR_RATE_4K;
    end else if (cfg_i.output_stage_select == fecr_pkg::FECR_STAGE_FIR1 &&
                 cfg_i.output_rate_select < fecr_pkg::FECR_RATE_250) begin
      eff_rate_o = fecr_pkg::FECR_RATE_250;
    end
  end

  // Codes above third-order IIR are reserved
  assign stage_rsvd_o =
    cfg_i.output_stage_select > fecr_pkg::FECR_STAGE_MAX;

endmodule : fecr_chain_decode

// ===== design/fecr_pkg.sv
// Constants, field layouts and reset values of the filter configuration bank.
// Assumes a single 100 MHz system clock domain.
package fecr_pkg;

  // Register addresses on the serial configuration port
  localparam logic [7:0] FECR_ADDR_ENGINE = 8'h00;
  localparam logic [7:0] FECR_ADDR_FILTER = 8'h20;

  // Reset images
  localparam logic [23:0] FECR_ENGINE_RST = 24'h050401;
  localparam logic [23:0] FECR_FILTER_RST = 24'h000000;

  // Output flops not covered by a register image
  localparam logic [2:0]  FECR_ENGINE_SEL_RST = 3'h5;
  localparam logic [2:0]  FECR_MCK_RATE_RST   = 3'h4;
  localparam logic [3:0]  FECR_LANE_RST       = 4'hF;

  // Writable bits; the rest read as zero, save the read-only engine boot flag
  localparam logic [23:0] FECR_ENGINE_WMASK = 24'h07773D;
  localparam logic [23:0] FECR_FILTER_WMASK = 24'h1F7773;

  // Read-only boot flag position
  localparam int FECR_BOOT_BIT = 1;

  // Clock select codes
  localparam logic [2:0] FECR_CLK_32K      = 3'h0;
  localparam logic [2:0] FECR_CLK_RSVD     = 3'h7;
  localparam logic [2:0] FECR_MCK_MIN      = 3'h2;
  localparam logic [2:0] FECR_MCK_MAX      = 3'h5;

  // Output stage codes
  localparam logic [2:0] FECR_STAGE_SINC   = 3'h0;
  localparam logic [2:0] FECR_STAGE_FIR1   = 3'h1;
  localparam logic [2:0] FECR_STAGE_MAX    = 3'h5;

  // Output rate codes
  localparam logic [2:0] FECR_RATE_4K      = 3'h7;
  localparam logic [2:0] FECR_RATE_250     = 3'h2;

  typedef struct packed {
    logic [4:0] rsvd_23_19;
    logic [2:0] engine_clock_select;
    logic       rsvd_15;
    logic [2:0] watchdog_clock_select;
    logic       rsvd_11;
    logic [2:0] modulator_clock_rate;
    logic [1:0] rsvd_7_6;
    logic       half_rate_clock_out_on;
    logic       modulator_clock_out_on;
    logic       modulator_input_rate;
    logic       standby_enable;
    logic       boot_from_prom;
    logic       modulator_sync_gate;
  } fecr_engine_cfg_s;

  typedef struct packed {
    logic [2:0] rsvd_23_21;
    logic [4:0] offset_trim_sensitivity;
    logic       rsvd_15;
    logic       offset_autotrim_on;
    logic       offset_correct_on;
    logic       gain_correct_on;
    logic       rsvd_11;
    logic [2:0] output_stage_select;
    logic       rsvd_7;
    logic [2:0] output_rate_select;
    logic [1:0] rsvd_3_2;
    logic [1:0] active_lane_count;
  } fecr_filter_cfg_s;

endpackage : fecr_pkg

// ===== design/fecr_top.sv
// Configuration register bank of the multi-channel decimation filter:
// engine clock register and filter chain register, plus their outputs.
// Assumes the serial port logic delivers one-cycle read and write strobes
// synchronous to sys_clk_i.
//
// What this block does
// - Engine clock select, 110 8.192 MHz down to 000 32 kHz, resets 101
// - Watchdog clock select uses the same codes, resets 000 (32 kHz)
// - Modulator clock rate 101..010 valid, others reserved, resets 100
// - Modulator input rate bit: 1 is 256 kHz, 0 is 512 kHz, resets 0
// - Standby bit puts the compute core in low-power low-frequency mode
// - Boot source flag is read-only: 1 from serial PROM, 0 from host
// - Sync gate 1 derives modulator sync from sync input, else low
// - Bits 4 and 5 enable modulator clock and half-rate clock outputs
// - Undefined register bits always read as zero
// - Output stage codes 000..101 sinc to third IIR, 110/111 reserved
// - Output rate codes 111 4 kHz down to 000 62.5 Hz
// - Lane count 01 one, 10 two, 11 three, 00 all four lanes
// - Correction and autotrim enables act when 1, idle when 0
`timescale 1ns/1ps
module fecr_top (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // Register port from the serial configuration logic
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [23:0] cfg_wdata_i,
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  output logic      [23:0] cfg_rdata_o,
  output logic             cfg_rvalid_o,
  // Boot strap and external sync
  input  wire logic        boot_from_prom_i,
  input  wire logic        sync_i,
  // Clocking controls
  output logic      [2:0]  engine_clock_select_o,
  output logic      [2:0]  watchdog_clock_select_o,
  output logic      [2:0]  modulator_clock_rate_o,
  output logic             clock_code_rsvd_o,
  output logic             modulator_input_rate_o,
  output logic             standby_enable_o,
  output logic             modulator_clock_out_on_o,
  output logic             half_rate_clock_out_on_o,
  output logic             modulator_sync_out_o,
  // Filter chain controls
  output logic      [4:0]  offset_trim_sensitivity_o,
  output logic             offset_autotrim_on_o,
  output logic             offset_correct_on_o,
  output logic             gain_correct_on_o,
  output logic      [2:0]  output_stage_select_o,
  output logic             output_stage_rsvd_o,
  output logic      [2:0]  output_rate_select_o,
  output logic      [3:0]  lane_enable_o
);

  fecr_pkg::fecr_engine_cfg_s engine_q;
  fecr_pkg::fecr_filter_cfg_s filter_q;
  logic                       boot_taken_q;
  logic [3:0]                 lane_mask_d;
  logic [2:0]                 eff_rate_d;
  logic                       stage_rsvd_d;
  logic [2:0]                 engine_sel_d;

  function automatic logic clk_code_rsvd(input logic [2:0] code);
    clk_code_rsvd = (code == fecr_pkg::FECR_CLK_RSVD);
  endfunction : clk_code_rsvd

  function automatic logic mck_code_rsvd(input logic [2:0] code);
    mck_code_rsvd = (code < fecr_pkg::FECR_MCK_MIN) ||
                    (code > fecr_pkg::FECR_MCK_MAX);
  endfunction : mck_code_rsvd

  // Engine clock register; boot flag is kept out of the write path
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      engine_q <= fecr_pkg::FECR_ENGINE_RST;
    end else if (cfg_wr_i && cfg_addr_i == fecr_pkg::FECR_ADDR_ENGINE) begin
      engine_q <= (cfg_wdata_i & fecr_pkg::FECR_ENGINE_WMASK) |
                  ({23'h000000, engine_q.boot_from_prom} <<
                   fecr_pkg::FECR_BOOT_BIT);
    end else if (!boot_taken_q) begin
      engine_q.boot_from_prom <= boot_from_prom_i;
    end
  end

  // Strap is caught once, on the first edge after reset release, unless an engine register write lands on that edge
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      boot_taken_q <= 1'b0;
    end else begin
      boot_taken_q <= 1'b1;
    end
  end

  // Filter chain register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      filter_q <= fecr_pkg::FECR_FILTER_RST;
    end else if (cfg_wr_i && cfg_addr_i == fecr_pkg::FECR_ADDR_FILTER) begin
      filter_q <= cfg_wdata_i & fecr_pkg::FECR_FILTER_WMASK;
    end
  end

  // Read port; unmapped addresses answer zero
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_rdata_o  <= 24'h000000;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i) begin
        unique case (cfg_addr_i)
          fecr_pkg::FECR_ADDR_ENGINE:
            cfg_rdata_o <= engine_q;
          fecr_pkg::FECR_ADDR_FILTER:
            cfg_rdata_o <= filter_q;
          default:
            cfg_rdata_o <= 24'h000000;
        endcase
      end
    end
  end

  // Standby forces the slowest engine clock regardless of the select;
  // the stored select is kept, so leaving standby restores the old rate
  assign engine_sel_d = engine_q.standby_enable ? fecr_pkg::FECR_CLK_32K
                                                : engine_q.engine_clock_select;

  // Engine clock as the compute core sees it
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      engine_clock_select_o <= fecr_pkg::FECR_ENGINE_SEL_RST;
      standby_enable_o      <= 1'b0;
    end else begin
      engine_clock_select_o <= engine_sel_d;
      standby_enable_o      <= engine_q.standby_enable;
    end
  end

  // Watchdog and modulator clock rates
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      watchdog_clock_select_o <= fecr_pkg::FECR_CLK_32K;
      modulator_clock_rate_o  <= fecr_pkg::FECR_MCK_RATE_RST;
    end else begin
      watchdog_clock_select_o <= engine_q.watchdog_clock_select;
      modulator_clock_rate_o  <= engine_q.modulator_clock_rate;
    end
  end

  // Reserved codes are stored as written; flagged, not rewritten, so a
  // read back always shows the code exactly as the host sent it
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clock_code_rsvd_o <= 1'b0;
    end else begin
      clock_code_rsvd_o <= clk_code_rsvd(engine_q.engine_clock_select) |
                           clk_code_rsvd(engine_q.watchdog_clock_select) |
                           mck_code_rsvd(engine_q.modulator_clock_rate);
    end
  end

  // Modulator link controls
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      modulator_input_rate_o   <= 1'b0;
      modulator_clock_out_on_o <= 1'b0;
      half_rate_clock_out_on_o <= 1'b0;
    end else begin
      modulator_input_rate_o   <= engine_q.modulator_input_rate;
      modulator_clock_out_on_o <= engine_q.modulator_clock_out_on;
      half_rate_clock_out_on_o <= engine_q.half_rate_clock_out_on;
    end
  end

  // Sync is passed through one flop; gate low holds it low
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      modulator_sync_out_o <= 1'b0;
    end else begin
      modulator_sync_out_o <= engine_q.modulator_sync_gate & sync_i;
    end
  end

  fecr_chain_decode fecr_chain_decode_i (
    .cfg_i        (filter_q),
    .lane_mask_o  (lane_mask_d),
    .eff_rate_o   (eff_rate_d),
    .stage_rsvd_o (stage_rsvd_d)
  );

  // Offset and gain correction controls
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      offset_trim_sensitivity_o <= 5'h00;
      offset_autotrim_on_o      <= 1'b0;
      offset_correct_on_o       <= 1'b0;
      gain_correct_on_o         <= 1'b0;
    end else begin
      offset_trim_sensitivity_o <= filter_q.offset_trim_sensitivity;
      offset_autotrim_on_o      <= filter_q.offset_autotrim_on;
      offset_correct_on_o       <= filter_q.offset_correct_on;
      gain_correct_on_o         <= filter_q.gain_correct_on;
    end
  end

  // Output stage and rate; the rate shown is one the chain can really run
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      output_stage_select_o <= fecr_pkg::FECR_STAGE_SINC;
      output_stage_rsvd_o   <= 1'b0;
      output_rate_select_o  <= fecr_pkg::FECR_RATE_4K;
    end else begin
      output_stage_select_o <= filter_q.output_stage_select;
      output_stage_rsvd_o   <= stage_rsvd_d;
      output_rate_select_o  <= eff_rate_d;
    end
  end

  // Lane enables
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lane_enable_o <= fecr_pkg::FECR_LANE_RST;
    end else begin
      lane_enable_o <= lane_mask_d;
    end
  end

endmodule : fecr_top

// ===== sim/fecr_host_model.sv
// Host model driving the register port with one-cycle strobes.
// Assumes reads are answered one edge after the strobe is taken.
`timescale 1ns/1ps
module fecr_host_model (
  // Answer side
  input  wire logic        sys_clk_i,
  input  wire logic [23:0] cfg_rdata_o,
  input  wire logic        cfg_rvalid_o,
  // Request side
  output logic      [7:0]  cfg_addr_i,
  output logic      [23:0] cfg_wdata_i,
  output logic             cfg_wr_i,
  output logic             cfg_rd_i
);
  initial begin
    cfg_addr_i = 8'h00;
    cfg_wdata_i = 24'h000000;
    cfg_wr_i = 1'b0;
    cfg_rd_i = 1'b0;
  end
  // Released lines show the inverse, so a stale value never matches
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(negedge sys_clk_i);
    cfg_addr_i = a;
    cfg_wdata_i = d;
    cfg_wr_i = 1'b1;
    @(negedge sys_clk_i);
    cfg_wr_i = 1'b0;
    cfg_addr_i = ~a;
    cfg_wdata_i = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [23:0] d,
                    output logic ok);
    @(negedge sys_clk_i);
    cfg_addr_i = a;
    cfg_rd_i = 1'b1;
    @(negedge sys_clk_i);
    cfg_rd_i = 1'b0;
    cfg_addr_i = ~a;
    ok = 1'b0;
    d = 24'h000000;
    // Answer stands for one cycle only: look before the next edge
    for (int n = 0; n < 4 && !ok; n++) begin
      if (cfg_rvalid_o === 1'b1) begin
        ok = 1'b1;
        d = cfg_rdata_o;
      end else begin
        @(negedge sys_clk_i);
      end
    end
  endtask : rd
endmodule : fecr_host_model

// ===== sim/fecr_properties.sv
// Checker of the configuration bank outputs, sees only the top ports.
// Assumes one clock domain and the host rules of the register port.
`timescale 1ns/1ps
module fecr_properties (
  // Clock, reset and port inputs
  input wire logic        sys_clk_i,
  input wire logic        resetn_i,
  input wire logic        cfg_rd_i,
  input wire logic        sync_i,
  // Watched outputs
  input wire logic        cfg_rvalid_o,
  input wire logic [23:0] cfg_rdata_o,
  input wire logic [2:0]  engine_clock_select_o,
  input wire logic [2:0]  watchdog_clock_select_o,
  input wire logic [2:0]  modulator_clock_rate_o,
  input wire logic        clock_code_rsvd_o,
  input wire logic        standby_enable_o,
  input wire logic        modulator_sync_out_o,
  input wire logic [2:0]  output_stage_select_o,
  input wire logic        output_stage_rsvd_o,
  input wire logic [2:0]  output_rate_select_o,
  input wire logic [3:0]  lane_enable_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_req; cfg_rd_i; endsequence
  sequence s_ans; cfg_rvalid_o; endsequence
  property p_rd; s_req |=> s_ans; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_norv; !cfg_rd_i |=> !cfg_rvalid_o; endproperty
  a_norv: assert property (p_norv) else $error("stray rvalid");
  property p_zero;
    s_ans |-> !cfg_rdata_o[23] && !cfg_rdata_o[15] && !cfg_rdata_o[11];
  endproperty
  a_zero: assert property (p_zero) else $error("undefined bit set");
  property p_sync; !sync_i |=> !modulator_sync_out_o; endproperty
  a_sync: assert property (p_sync) else $error("sync out not gated");
  property p_sby; standby_enable_o |-> engine_clock_select_o == 3'h0;
  endproperty
  a_sby: assert property (p_sby) else $error("standby clock wrong");
  property p_mrsv;
    (modulator_clock_rate_o[2:1] == 2'b11 || modulator_clock_rate_o[2:1]
      == 2'b00 || watchdog_clock_select_o == 3'h7) |-> clock_code_rsvd_o;
  endproperty
  a_mrsv: assert property (p_mrsv) else $error("rsvd unflagged");
  property p_lane; lane_enable_o inside {4'h1, 4'h3, 4'h7, 4'hF};
  endproperty
  a_lane: assert property (p_lane) else $error("lane mask gap");
  property p_srsv;
    output_stage_rsvd_o == (output_stage_select_o[2:1] == 2'b11);
  endproperty
  a_srsv: assert property (p_srsv) else $error("stage flag wrong");
  property p_sinc;
    output_stage_select_o == 3'h0 |-> output_rate_select_o == 3'h7;
  endproperty
  a_sinc: assert property (p_sinc) else $error("sinc rate wrong");
endmodule : fecr_properties
bind fecr_top fecr_properties fecr_properties_i (
  .sys_clk_i               (sys_clk_i),
  .resetn_i                (resetn_i),
  .cfg_rd_i                (cfg_rd_i),
  .sync_i                  (sync_i),
  .cfg_rvalid_o            (cfg_rvalid_o),
  .cfg_rdata_o             (cfg_rdata_o),
  .engine_clock_select_o   (engine_clock_select_o),
  .watchdog_clock_select_o (watchdog_clock_select_o),
  .modulator_clock_rate_o  (modulator_clock_rate_o),
  .clock_code_rsvd_o       (clock_code_rsvd_o),
  .standby_enable_o        (standby_enable_o),
  .modulator_sync_out_o    (modulator_sync_out_o),
  .output_stage_select_o   (output_stage_select_o),
  .output_stage_rsvd_o     (output_stage_rsvd_o),
  .output_rate_select_o    (output_rate_select_o),
  .lane_enable_o           (lane_enable_o)
);

// ===== sim/test_fecr_top.sv
// Self-checking bench of the configuration bank, one task a scenario.
// Assumes the host model drives the port at the falling edge.
`timescale 1ns/1ps
module test_fecr_top;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, boot_from_prom_i = 1'b1;
  logic sync_i = 1'b0, cfg_wr_i, cfg_rd_i, cfg_rvalid_o, clock_code_rsvd_o;
  logic [7:0] cfg_addr_i;
  logic [23:0] cfg_wdata_i, cfg_rdata_o;
  logic [2:0] engine_clock_select_o, watchdog_clock_select_o;
  logic [2:0] modulator_clock_rate_o, output_stage_select_o;
  logic [2:0] output_rate_select_o;
  logic modulator_input_rate_o, standby_enable_o, modulator_clock_out_on_o;
  logic half_rate_clock_out_on_o, modulator_sync_out_o, offset_autotrim_on_o;
  logic offset_correct_on_o, gain_correct_on_o, output_stage_rsvd_o;
  logic [4:0] offset_trim_sensitivity_o;
  logic [3:0] lane_enable_o;
  int failures = 0, n_compared = 0;
  fecr_top fecr_top_i (
    .sys_clk_i                 (sys_clk_i),
    .resetn_i                  (resetn_i),
    .cfg_addr_i                (cfg_addr_i),
    .cfg_wdata_i               (cfg_wdata_i),
    .cfg_wr_i                  (cfg_wr_i),
    .cfg_rd_i                  (cfg_rd_i),
    .cfg_rdata_o               (cfg_rdata_o),
    .cfg_rvalid_o              (cfg_rvalid_o),
    .boot_from_prom_i          (boot_from_prom_i),
    .sync_i                    (sync_i),
    .engine_clock_select_o     (engine_clock_select_o),
    .watchdog_clock_select_o   (watchdog_clock_select_o),
    .modulator_clock_rate_o    (modulator_clock_rate_o),
    .clock_code_rsvd_o         (clock_code_rsvd_o),
    .modulator_input_rate_o    (modulator_input_rate_o),
    .standby_enable_o          (standby_enable_o),
    .modulator_clock_out_on_o  (modulator_clock_out_on_o),
    .half_rate_clock_out_on_o  (half_rate_clock_out_on_o),
    .modulator_sync_out_o      (modulator_sync_out_o),
    .offset_trim_sensitivity_o (offset_trim_sensitivity_o),
    .offset_autotrim_on_o      (offset_autotrim_on_o),
    .offset_correct_on_o       (offset_correct_on_o),
    .gain_correct_on_o         (gain_correct_on_o),
    .output_stage_select_o     (output_stage_select_o),
    .output_stage_rsvd_o       (output_stage_rsvd_o),
    .output_rate_select_o      (output_rate_select_o),
    .lane_enable_o             (lane_enable_o)
  );
  fecr_host_model fecr_host_model_i (
    .sys_clk_i    (sys_clk_i),
    .cfg_rdata_o  (cfg_rdata_o),
    .cfg_rvalid_o (cfg_rvalid_o),
    .cfg_addr_i   (cfg_addr_i),
    .cfg_wdata_i  (cfg_wdata_i),
    .cfg_wr_i     (cfg_wr_i),
    .cfg_rd_i     (cfg_rd_i)
  );
  always #5 sys_clk_i = ~sys_clk_i;
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [23:0] e);
    logic [23:0] d;
    logic ok;
    fecr_host_model_i.rd(a, d, ok);
    if (!ok) begin
      failures++;
      $display("[FAIL] %0t rvalid %h exp %h", $time, ok, 1'b1);
      conclude();
    end else begin
      chk(d, e);
    end
  endtask : rdc
  task automatic wrs(input logic [7:0] a, input logic [23:0] d);
    fecr_host_model_i.wr(a, d);
    repeat (2) @(negedge sys_clk_i);
  endtask : wrs
  task automatic t_reset();
    rdc(8'h00, 24'h050403);
    rdc(8'h20, 24'h000000);
    chk(24'({engine_clock_select_o, watchdog_clock_select_o,
      modulator_clock_rate_o}), 24'h000144);
    chk(24'({lane_enable_o, output_rate_select_o}), 24'h00007F);
    sync_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk(24'(modulator_sync_out_o), 24'h000001);
    $display("reset test done");
  endtask : t_reset
  task automatic t_engine();
    wrs(8'h00, 24'hFFFFFF);
    chk(24'({standby_enable_o, engine_clock_select_o, clock_code_rsvd_o}),
      24'h000011);
    rdc(8'h00, 24'h07773F);
    wrs(8'h00, 24'h060530);
    chk(24'({engine_clock_select_o, modulator_clock_rate_o,
      modulator_clock_out_on_o, half_rate_clock_out_on_o,
      modulator_input_rate_o, modulator_sync_out_o}),
      24'h00035C);
    rdc(8'h00, 24'h060532);
    wrs(8'h00, 24'h05040D);
    chk(24'({engine_clock_select_o, modulator_input_rate_o,
      modulator_sync_out_o}), 24'h000003);
    wrs(8'h00, 24'h050100);
    chk(24'(clock_code_rsvd_o), 24'h000001);
    $display("engine test done");
  endtask : t_engine
  task automatic t_filter();
    logic [3:0] lanes [4] = '{4'hF, 4'h1, 4'h3, 4'h7};
    logic [15:0] tab [4] = '{16'h0270, 16'h1020, 16'h5110, 16'h6441};
    for (int c = 0; c < 4; c++) begin
      wrs(8'h20, 24'h1F7230 | 24'(c));
      chk(24'({lane_enable_o, offset_trim_sensitivity_o, offset_autotrim_on_o,
        offset_correct_on_o, gain_correct_on_o, output_rate_select_o}),
        24'({lanes[c], 11'h7FB}));
      rdc(8'h20, 24'h1F7230 | 24'(c));
    end
    for (int i = 0; i < 4; i++) begin
      wrs(8'h20, 24'({tab[i][14:12], 1'b0, tab[i][10:8], 4'h0}));
      chk(24'({output_stage_select_o, output_stage_rsvd_o,
        output_rate_select_o, offset_correct_on_o}),
        24'({tab[i][14:12], tab[i][0], tab[i][6:4], 1'b0}));
    end
    wrs(8'h10, 24'hFFFFFF);
    rdc(8'h10, 24'h000000);
    rdc(8'h20, 24'h000640);
    $display("filter test done");
  endtask : t_filter
  // Mid-run reset with the strap low; strap is then raised too late
  task automatic t_reboot();
    @(negedge sys_clk_i);
    resetn_i = 1'b0;
    boot_from_prom_i = 1'b0;
    @(negedge sys_clk_i);
    chk(24'({cfg_rvalid_o, engine_clock_select_o, modulator_clock_rate_o,
      lane_enable_o}), 24'h0002CF);
    repeat (2) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    boot_from_prom_i = 1'b1;
    rdc(8'h00, 24'h050401);
    rdc(8'h20, 24'h000000);
    $display("reboot test done");
  endtask : t_reboot
  initial begin
    repeat (8) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    t_reset();
    t_engine();
    t_filter();
    t_reboot();
    conclude();
  end
endmodule : test_fecr_top
